//--- hw/spc_pkg.sv
// Package: register map, fields and sequencer states of the sleep power control block
package spc_pkg;
  localparam int SPC_ADDR_W = 4;
  localparam logic [SPC_ADDR_W-1:0] SPC_OFF_CTRL = 4'h0;
  localparam logic [SPC_ADDR_W-1:0] SPC_OFF_LOCK = 4'h4;
  localparam logic [SPC_ADDR_W-1:0] SPC_OFF_STAT = 4'h8;
  localparam int SPC_BIT_REG_STBY = 0;
  localparam int SPC_BIT_SLEEP_RETENTION_SELECT = 1;
  localparam int SPC_BIT_SBOR = 2;
  localparam int SPC_CTRL_W = 3;
  localparam logic [SPC_CTRL_W-1:0] SPC_CTRL_RESET = 3'h0;
  localparam logic [1:0] SPC_BOR_SLEEP_SW = 2'h1;
  localparam logic [31:0] SPC_KEY_1 = 32'haa996655;
  localparam logic [31:0] SPC_KEY_2 = 32'h556699aa;
  localparam logic [31:0] SPC_KEY_LOCK = 32'h00000000;
  localparam logic [31:0] SPC_UNMAPPED_DATA = 32'h00000000;
  typedef enum logic [2:0] {
    SPC_LK_LOCKED = 3'b001,
    SPC_LK_HALF = 3'b010,
    SPC_LK_OPEN = 3'b100
  } spc_lock_e;
endpackage

//--- hw/spc_top.sv
// Module: sleep power control register with Avalon-MM slave and sleep outputs
//
// Operation
// - Upper bits 31 to 3 of the control register always read zero.
// - Sleep brown-out bit set keeps brown-out detection running in sleep.
// - Sleep brown-out bit counts only when brown-out config field equals 01.
// - Retention bit one puts main regulator in low-power state during sleep.
// - Standby bit one keeps regulator active in sleep; zero means standby.
// - Software unlocks system registers first; only then are control writes taken.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module spc_top
  import spc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int BE_W = 4
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [SPC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [BE_W-1:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] brownout_config_field,
  input wire logic sleep_active,
  output logic sleep_brownout_on,
  output logic sleep_retention_select,
  output logic regulator_standby_select,
  output logic bor_enable_in_sleep,
  output logic main_reg_lowpower,
  output logic regulator_standby,
  output logic write_rejected
);
  spc_unlock_if ulk ();

  // Widths the register map and key path are built for
  generate
    if (DATA_W != 32) begin : g_bad_data_w
      $error("spc_top: DATA_W must be 32");
    end
    if (BE_W != DATA_W / 8) begin : g_bad_be_w
      $error("spc_top: BE_W must be DATA_W / 8");
    end
  endgenerate

  logic [SPC_CTRL_W-1:0] ctrl;
  logic [SPC_CTRL_W-1:0] next_ctrl;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic rejected;
  logic next_rejected;
  logic bor_sleep;
  logic next_bor_sleep;
  logic reg_lp;
  logic next_reg_lp;
  logic reg_stby;
  logic next_reg_stby;

  spc_unlock u_unlock (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .ulk(ulk)
  );

  // Address decode shared by the key and control paths
  function automatic logic addr_is(input logic [SPC_ADDR_W-1:0] addr,
                                   input logic [SPC_ADDR_W-1:0] off);
    addr_is = (addr == off);
  endfunction

  // Key writes count only as full words
  function automatic logic full_word(input logic [BE_W-1:0] be);
    full_word = &be;
  endfunction

  // Accesses complete one cycle after being presented
  logic req;
  logic wr_fire;
  logic ctrl_hit;
  logic next_waitrequest;
  logic [SPC_CTRL_W-1:0] ctrl_wr_val;
  assign req = (avs_read | avs_write) & ~ack;
  assign wr_fire = avs_write & ack;
  assign ctrl_hit = wr_fire & addr_is(avs_address, SPC_OFF_CTRL) & avs_byteenable[0];
  assign ulk.key_we = wr_fire & addr_is(avs_address, SPC_OFF_LOCK) & full_word(avs_byteenable);
  assign ulk.key_data = avs_writedata;

  // Value a control write leaves in each bit
  for (genvar i = 0; i < SPC_CTRL_W; i++) begin : g_ctrl_bit
    if (i == SPC_BIT_SLEEP_RETENTION_SELECT) begin : g_set_only
      assign ctrl_wr_val[i] = ctrl[i] | avs_writedata[i];
    end else begin : g_plain
      assign ctrl_wr_val[i] = avs_writedata[i];
    end
  end

  // Bus handshake and read data
  always_comb begin
    next_ack = req;
    next_waitrequest = ~req;
    next_readdata = avs_readdata;
    if (req) begin
      next_readdata = SPC_UNMAPPED_DATA;
    end
    if (req && avs_read) begin
      unique case (avs_address)
        SPC_OFF_CTRL: next_readdata = {29'h0, ctrl};
        SPC_OFF_STAT: next_readdata = {30'h0, rejected, ulk.unlocked};
        default: next_readdata = SPC_UNMAPPED_DATA;
      endcase
    end
  end

  // Control register and reject flag
  always_comb begin
    next_ctrl = ctrl;
    next_rejected = rejected;
    if (ctrl_hit) begin
      if (ulk.unlocked) begin
        next_ctrl = ctrl_wr_val;
        next_rejected = 1'b0;
      end else begin
        next_rejected = 1'b1;
      end
    end
  end

  // Sleep outputs, one cycle behind their inputs
  always_comb begin
    next_bor_sleep = sleep_active & ctrl[SPC_BIT_SBOR] &
                     (brownout_config_field == SPC_BOR_SLEEP_SW);
    next_reg_lp = sleep_active & ctrl[SPC_BIT_SLEEP_RETENTION_SELECT];
    next_reg_stby = sleep_active & ~ctrl[SPC_BIT_REG_STBY];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ack <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= SPC_UNMAPPED_DATA;
    end else if (clk_en) begin
      ack <= next_ack;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl <= SPC_CTRL_RESET;
      rejected <= 1'b0;
    end else if (clk_en) begin
      ctrl <= next_ctrl;
      rejected <= next_rejected;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bor_sleep <= 1'b0;
      reg_lp <= 1'b0;
      reg_stby <= 1'b0;
    end else if (clk_en) begin
      bor_sleep <= next_bor_sleep;
      reg_lp <= next_reg_lp;
      reg_stby <= next_reg_stby;
    end
  end

  // Outputs taken straight from the registers above

  assign sleep_brownout_on = ctrl[SPC_BIT_SBOR];
  assign sleep_retention_select = ctrl[SPC_BIT_SLEEP_RETENTION_SELECT];
  assign regulator_standby_select = ctrl[SPC_BIT_REG_STBY];
  assign bor_enable_in_sleep = bor_sleep;
  assign main_reg_lowpower = reg_lp;
  assign regulator_standby = reg_stby;
  assign write_rejected = rejected;
endmodule // spc_top

//--- hw/spc_unlock.sv
// Module: system unlock key sequencer
`timescale 1ns/10ps
module spc_unlock
  import spc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  spc_unlock_if.lock ulk
);
  spc_lock_e state;
  spc_lock_e next_state;

  always_comb begin
    next_state = state;
    if (ulk.key_we) begin
      unique case (state)
        SPC_LK_LOCKED: next_state = (ulk.key_data == SPC_KEY_1) ? SPC_LK_HALF : SPC_LK_LOCKED;
        SPC_LK_HALF: next_state = (ulk.key_data == SPC_KEY_2) ? SPC_LK_OPEN : SPC_LK_LOCKED;
        SPC_LK_OPEN: next_state = (ulk.key_data == SPC_KEY_LOCK) ? SPC_LK_LOCKED : SPC_LK_OPEN;
        default: next_state = SPC_LK_LOCKED;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= SPC_LK_LOCKED;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign ulk.unlocked = (state == SPC_LK_OPEN);
endmodule // spc_unlock

//--- hw/spc_unlock_if.sv
// Interface: unlock key writes and resulting unlock state
`timescale 1ns/10ps
interface spc_unlock_if;
  logic key_we;
  logic [31:0] key_data;
  logic unlocked;
  modport ctrl (output key_we, output key_data, input unlocked);
  modport lock (input key_we, input key_data, output unlocked);
endinterface

//--- testbench/spc_properties.sv
// Checker: sleep power control port properties
`timescale 1ns/10ps
module spc_properties
  import spc_pkg::*;
(
  input wire logic core_clk, rst_b, clk_en, avs_read, avs_write, avs_waitrequest,
  input wire logic [SPC_ADDR_W-1:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata, avs_readdata,
  input wire logic [1:0] brownout_config_field,
  input wire logic sleep_active, sleep_brownout_on, sleep_retention_select,
  input wire logic regulator_standby_select, bor_enable_in_sleep, main_reg_lowpower,
  input wire logic regulator_standby, write_rejected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic wr_done;
  logic [2:0] ctl;
  assign wr_done = clk_en && avs_write && !avs_waitrequest && avs_address == SPC_OFF_CTRL
    && avs_byteenable[0];
  assign ctl = {sleep_brownout_on, sleep_retention_select, regulator_standby_select};
  upper_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == SPC_OFF_CTRL
    |-> avs_readdata[31:3] == 29'h0) else $error("upper bits not zero");
  bor_sleep_a: assert property (clk_en |=> bor_enable_in_sleep ==
    $past(sleep_active && sleep_brownout_on && brownout_config_field == SPC_BOR_SLEEP_SW))
    else $error("brown-out sleep output wrong");
  cfg_gate_a: assert property (clk_en && brownout_config_field != SPC_BOR_SLEEP_SW
    |=> !bor_enable_in_sleep) else $error("brown-out on under wrong config");
  ret_sleep_a: assert property (clk_en |=>
    main_reg_lowpower == $past(sleep_active && sleep_retention_select))
    else $error("low-power output wrong");
  stby_sleep_a: assert property (clk_en |=>
    regulator_standby == $past(sleep_active && !regulator_standby_select))
    else $error("standby output wrong");
  open_store_a: assert property (wr_done ##1 !write_rejected |->
    ctl == ($past(avs_writedata[2:0]) | {1'b0, $past(sleep_retention_select), 1'b0}))
    else $error("accepted write not stored");
  locked_drop_a: assert property (wr_done ##1 write_rejected |-> $stable(ctl))
    else $error("locked write changed bits");
  ret_sticky_a: assert property (sleep_retention_select |=> sleep_retention_select)
    else $error("retention bit cleared by write");
  cover property (wr_done ##1 !write_rejected);
  cover property (wr_done ##1 write_rejected);
  cover property (bor_enable_in_sleep);
endmodule // spc_properties
bind spc_top spc_properties u_props (.*);

//--- testbench/test_spc_top.sv
// Testbench: register access and sleep output checks
`timescale 1ns/10ps
module test_spc_top
  import spc_pkg::*;
;
  logic core_clk = 1'h0, rst_b = 1'h0, avs_read = 1'h0, avs_write = 1'h0, sleep_active = 1'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [1:0] brownout_config_field = 2'h0;
  logic avs_waitrequest, sleep_brownout_on, sleep_retention_select, regulator_standby_select;
  logic bor_enable_in_sleep, main_reg_lowpower, regulator_standby, write_rejected;
  int fail_count = 0, tests_run = 0, cyc = 0;
  logic clk_en = 1'h1;
  spc_top u_dut (.*);
  initial forever #2 core_clk = ~core_clk;
  task wrap_up;
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input string n);
    acc(1'h0, a, 32'h0);
    chk(n, e, q);
  endtask
  task sl(input logic [1:0] c, input logic [2:0] e);
    brownout_config_field <= c;
    repeat (3) @(posedge core_clk);
    chk("sleep outs", {29'h0, e},
      {29'h0, bor_enable_in_sleep, main_reg_lowpower, regulator_standby});
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'h1;
    rd(SPC_OFF_CTRL, 32'h0, "ctrl reset");
    acc(1'h1, SPC_OFF_CTRL, 32'h7);
    rd(SPC_OFF_CTRL, 32'h0, "ctrl locked");
    chk("rejected", 32'h1, {31'h0, write_rejected});
    rd(SPC_OFF_STAT, 32'h2, "status locked");
    acc(1'h1, SPC_OFF_LOCK, SPC_KEY_1);
    acc(1'h1, SPC_OFF_LOCK, SPC_KEY_2);
    acc(1'h1, SPC_OFF_CTRL, 32'hffffffff);
    rd(SPC_OFF_CTRL, 32'h7, "ctrl open");
    chk("accepted", 32'h0, {31'h0, write_rejected});
    rd(SPC_OFF_STAT, 32'h1, "status open");
    chk("ctrl pins", 32'h7, {29'h0, sleep_brownout_on, sleep_retention_select,
      regulator_standby_select});
    sleep_active <= 1'h1;
    for (int c = 0; c < 4; c++) sl(2'(c), {c == 1, 2'h2});
    acc(1'h1, SPC_OFF_CTRL, 32'h0);
    rd(SPC_OFF_CTRL, 32'h2, "ctrl zero write");
    sl(2'h1, 3'h3);
    clk_en <= 1'h0;
    sleep_active <= 1'h0;
    repeat (3) @(posedge core_clk);
    chk("frozen", 32'h3, {29'h0, bor_enable_in_sleep, main_reg_lowpower, regulator_standby});
    clk_en <= 1'h1;
    repeat (2) @(posedge core_clk);
    chk("awake", 32'h0, {29'h0, bor_enable_in_sleep, main_reg_lowpower, regulator_standby});
    rd(4'hc, 32'h0, "unmapped");
    acc(1'h1, SPC_OFF_LOCK, 32'h0);
    acc(1'h1, SPC_OFF_CTRL, 32'h5);
    rd(SPC_OFF_CTRL, 32'h2, "ctrl relocked");
    wrap_up;
  end
endmodule // test_spc_top
